// file: rtl/shs_defines.vh
// Constants for the servo homing sequencer: register offsets, fields, resets.
// Assumes a 32-bit AHB-Lite register bus with one aligned word per register.
`ifndef SHS_DEFINES_VH
`define SHS_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define SHS_A_CTRL 8'h00
`define SHS_A_MODE 8'h04
`define SHS_A_DPEAK 8'h08
`define SHS_A_HPEAK 8'h0C
`define SHS_A_THRESH 8'h10
`define SHS_A_HOMEP 8'h14
`define SHS_A_DIST 8'h18
`define SHS_A_LIMP 8'h1C
`define SHS_A_LIMN 8'h20
`define SHS_A_STAT 8'h24
`define SHS_A_IRQST 8'h28
`define SHS_A_IRQEN 8'h2C
`define SHS_A_IRQCLR 8'h30
`define SHS_A_CMD 8'h34

// ****************************************
// Fields and values
// ****************************************
`define SHS_CTRL_OPM_LO 0
`define SHS_CTRL_OPM_HI 1
`define SHS_CTRL_SRC_LO 2
`define SHS_CTRL_SRC_HI 3
`define SHS_CTRL_REQ 4
`define SHS_OPMODE_POS 2'h2
`define SHS_SRC_NET 2'h0
`define SHS_CMD_START 0
`define SHS_CMD_MOTION 1
`define SHS_IRQ_DONE 0
`define SHS_IRQ_REFUSE 1
`define SHS_IRQ_STOP 2
`define SHS_PEAK_DIV 16'h0078

// ****************************************
// Reset values
// ****************************************
`define SHS_RST_CTRL 5'h10
`define SHS_RST_MODE 4'h0
`define SHS_RST_DPEAK 16'h7800
`define SHS_RST_HPEAK 16'h0100

`endif

// file: rtl/shs_mag.v
// Absolute value of a signed following error, registered.
// Assumes one clock and an asynchronous active-low reset.
module shs_mag (
	input wire MCLK,            // System clock
	input wire RST_B,           // Async reset, active low
	input wire [31:0] err,      // Signed following error
	output reg [31:0] mag       // Magnitude, one cycle late
);
	// Register the magnitude to keep the compare path short
	always @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			mag <= 32'h00000000;
		end else begin
			mag <= err[31] ? (32'h00000000 - err) : err;
		end
	end
endmodule

// file: rtl/shs_top.v
// Homing sequencer: picks a homing procedure, clamps current, loads home position.
// Assumes an AHB-Lite master, and motor/switch/feedback inputs synchronous to MCLK.
`include "shs_defines.vh"
module shs_top (
	input wire MCLK,              // 40 MHz clock
	input wire RST_B,             // Async reset, active low
	input wire [31:0] HADDR,      // AHB address
	input wire [1:0] HTRANS,      // AHB transfer type
	input wire HWRITE,            // AHB write
	input wire [2:0] HSIZE,       // AHB size, word only
	input wire [31:0] HWDATA,     // AHB write data
	input wire HSEL,              // AHB slave select
	input wire HREADY,            // AHB bus ready
	output reg [31:0] HRDATA,     // AHB read data
	output reg HREADYOUT,         // AHB ready out
	output reg HRESP,             // AHB response, always OKAY
	input wire [31:0] FOLLOW_ERR, // Signed following error
	input wire LIMIT_SW,          // Limit switch hit
	input wire HOME_SW,           // Home switch hit
	input wire INDEX_PULSE,       // Feedback index pulse
	input wire ZERO_ANGLE,        // Feedback at zero angle
	input wire MOVE_DONE,         // Commanded move finished
	output reg [31:0] POS_LOAD,   // Home position to load
	output reg POS_LOAD_STB,      // Load command and actual positions
	output reg [15:0] LIMIT_POS,  // Positive current limit in use
	output reg [15:0] LIMIT_NEG,  // Negative current limit in use
	output reg SEEK_ACTIVE,       // Homing search motion running
	output reg OFFSET_MOVE,       // Post-home offset move pulse
	output reg [31:0] OFFSET_DIST,// Offset move distance
	output reg MOTION_GO,         // Motion task accepted pulse
	output reg HOME_DONE,         // Homing complete status
	output reg IRQ                // Level interrupt
);
	// ****************************************
	// States and locals
	// ****************************************
	localparam ST_IDLE = 2'h0;
	localparam ST_SEEK = 2'h1;
	localparam ST_SECOND = 2'h2;
	localparam ST_OFFSET = 2'h3;

	reg [4:0] ctrl;
	reg [3:0] home_mode;
	reg [15:0] drive_peak_current;
	reg [15:0] homing_current_clamp;
	reg [31:0] stop_lag_threshold;
	reg [31:0] home_position;
	reg [31:0] post_home_offset_move;
	reg [15:0] positive_current_limit;
	reg [15:0] negative_current_limit;
	reg [2:0] irq_status;
	reg [2:0] irq_enable;
	reg [1:0] state;
	reg [1:0] next_state;
	reg clamp_on;
	reg ph_valid;
	reg ph_write;
	reg [7:0] ph_addr;
	reg stop_prev;
	wire [31:0] lag_mag;
	wire [1:0] drive_operating_mode;
	wire [1:0] command_source_select;
	wire homing_required_flag;
	wire pos_mode;
	wire stop_hit;
	wire stop_edge;
	wire clamp_next;
	wire second_event;
	wire wr;
	wire start_req;
	wire motion_req;
	wire refuse;
	reg home_event;

	assign drive_operating_mode = ctrl[`SHS_CTRL_OPM_HI:`SHS_CTRL_OPM_LO];
	assign command_source_select = ctrl[`SHS_CTRL_SRC_HI:`SHS_CTRL_SRC_LO];
	assign homing_required_flag = ctrl[`SHS_CTRL_REQ];
	assign pos_mode = (drive_operating_mode == `SHS_OPMODE_POS);

	// Mechanical-stop procedures: 8, 9, 10 and 12
	function is_stop_mode;
		input [3:0] m;
		begin
			is_stop_mode = (m == 4'h8) || (m == 4'h9) || (m == 4'hA) || (m == 4'hC);
		end
	endfunction

	// Clamp applies only to the two plain stop modes
	function is_clamp_mode;
		input [3:0] m;
		begin
			is_clamp_mode = (m == 4'h8) || (m == 4'h9);
		end
	endfunction

	// ****************************************
	// Following-error magnitude
	// ****************************************
	shs_mag u_mag (
		.MCLK(MCLK),
		.RST_B(RST_B),
		.err(FOLLOW_ERR),
		.mag(lag_mag)
	);

	assign stop_hit = (lag_mag > stop_lag_threshold);
	assign stop_edge = stop_hit && !stop_prev;

	// ****************************************
	// Bus slave
	// ****************************************
	// Address phase captured; zero wait states, so data phase is one cycle
	always @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			ph_valid <= 1'b0;
			ph_write <= 1'b0;
			ph_addr <= 8'h00;
		end else if (HREADY) begin
			ph_valid <= HSEL && HTRANS[1];
			ph_write <= HWRITE;
			ph_addr <= HADDR[7:0];
		end
	end

	assign wr = ph_valid && ph_write;
	assign start_req = wr && (ph_addr == `SHS_A_CMD) && HWDATA[`SHS_CMD_START];
	assign motion_req = wr && (ph_addr == `SHS_A_CMD) && HWDATA[`SHS_CMD_MOTION];
	// Motion blocked while homing is required and not done
	assign refuse = motion_req && homing_required_flag && !HOME_DONE;

	// Writable settings; the required flag resets to 1 as its stored default
	always @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl <= `SHS_RST_CTRL;
			home_mode <= `SHS_RST_MODE;
			drive_peak_current <= `SHS_RST_DPEAK;
			homing_current_clamp <= `SHS_RST_HPEAK;
			stop_lag_threshold <= 32'h00000000;
			home_position <= 32'h00000000;
			post_home_offset_move <= 32'h00000000;
			irq_enable <= 3'h0;
		end else if (wr) begin
			case (ph_addr)
				`SHS_A_CTRL: ctrl <= HWDATA[4:0];
				`SHS_A_DPEAK: begin
					drive_peak_current <= HWDATA[15:0];
					// Default follows the drive peak; every drive peak write replaces any value software set
					homing_current_clamp <= HWDATA[15:0] / `SHS_PEAK_DIV;
				end
				`SHS_A_IRQEN: irq_enable <= HWDATA[2:0];
				default: begin
					// Homing settings only take in position mode
					if (pos_mode) begin
						case (ph_addr)
							`SHS_A_MODE: home_mode <= HWDATA[3:0];
							`SHS_A_HPEAK: homing_current_clamp <= HWDATA[15:0];
							`SHS_A_THRESH: stop_lag_threshold <= HWDATA;
							`SHS_A_HOMEP: home_position <= HWDATA;
							`SHS_A_DIST: post_home_offset_move <= HWDATA;
							default: ;
						endcase
					end
				end
			endcase
		end
	end

	// Prior current limits, software owned
	always @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			positive_current_limit <= `SHS_RST_DPEAK;
			negative_current_limit <= `SHS_RST_DPEAK;
		end else if (wr && ph_addr == `SHS_A_LIMP) begin
			positive_current_limit <= HWDATA[15:0];
		end else if (wr && ph_addr == `SHS_A_LIMN) begin
			negative_current_limit <= HWDATA[15:0];
		end
	end

	// Read mux and response, registered for flop-driven outputs
	always @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			HRDATA <= 32'h00000000;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end else begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
			case (HADDR[7:0])
				`SHS_A_CTRL: HRDATA <= {27'h0000000, ctrl};
				`SHS_A_MODE: HRDATA <= {28'h0000000, home_mode};
				`SHS_A_DPEAK: HRDATA <= {16'h0000, drive_peak_current};
				`SHS_A_HPEAK: HRDATA <= {16'h0000, homing_current_clamp};
				`SHS_A_THRESH: HRDATA <= stop_lag_threshold;
				`SHS_A_HOMEP: HRDATA <= home_position;
				`SHS_A_DIST: HRDATA <= post_home_offset_move;
				`SHS_A_LIMP: HRDATA <= {16'h0000, positive_current_limit};
				`SHS_A_LIMN: HRDATA <= {16'h0000, negative_current_limit};
				`SHS_A_STAT: HRDATA <= {27'h0000000, state, clamp_on, SEEK_ACTIVE, HOME_DONE};
				`SHS_A_IRQST: HRDATA <= {29'h00000000, irq_status};
				`SHS_A_IRQEN: HRDATA <= {29'h00000000, irq_enable};
				default: HRDATA <= 32'h00000000;
			endcase
		end
	end

	// ****************************************
	// Homing event decode
	// ****************************************
	// Clamp decided one edge ahead, so limits switch on the same edge as the seek flag
	assign clamp_next = ((next_state == ST_SEEK) || (next_state == ST_SECOND)) && is_clamp_mode(home_mode);
	// First stage event for each procedure
	always @* begin
		home_event = 1'b0;
		case (home_mode)
			4'h0, 4'hD: home_event = 1'b1;
			4'h1: home_event = LIMIT_SW;
			4'h4: home_event = HOME_SW;
			4'h7: home_event = ZERO_ANGLE;
			4'h8: home_event = stop_edge;
			4'hB: home_event = INDEX_PULSE;
			4'hC: home_event = HOME_SW || stop_edge;
			4'h2, 4'h3: home_event = LIMIT_SW;
			4'h5, 4'h6: home_event = HOME_SW;
			4'h9, 4'hA: home_event = stop_edge;
			default: home_event = 1'b0;
		endcase
	end

	// Two-stage modes finish on zero angle or index
	assign second_event = (home_mode == 4'h2 || home_mode == 4'h5 || home_mode == 4'h9) ? ZERO_ANGLE : INDEX_PULSE;

	// ****************************************
	// Sequencer
	// ****************************************
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE:
				if (start_req && pos_mode && command_source_select == `SHS_SRC_NET) begin
					next_state = ST_SEEK;
				end
			ST_SEEK:
				if (!pos_mode) begin
					next_state = ST_IDLE;
				end else if (home_event) begin
					case (home_mode)
						4'h2, 4'h3, 4'h5, 4'h6, 4'h9, 4'hA: next_state = ST_SECOND;
						default: next_state = (post_home_offset_move != 32'h00000000) ? ST_OFFSET : ST_IDLE;
					endcase
				end
			ST_SECOND:
				if (!pos_mode) begin
					next_state = ST_IDLE;
				end else if (second_event) begin
					next_state = (post_home_offset_move != 32'h00000000) ? ST_OFFSET : ST_IDLE;
				end
			ST_OFFSET:
				if (MOVE_DONE || !pos_mode) begin
					next_state = ST_IDLE;
				end
			default: next_state = ST_IDLE;
		endcase
	end

	// State, position load, offset move and done status
	always @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			state <= ST_IDLE;
			stop_prev <= 1'b0;
			clamp_on <= 1'b0;
			POS_LOAD <= 32'h00000000;
			POS_LOAD_STB <= 1'b0;
			SEEK_ACTIVE <= 1'b0;
			OFFSET_MOVE <= 1'b0;
			OFFSET_DIST <= 32'h00000000;
			HOME_DONE <= 1'b0;
			MOTION_GO <= 1'b0;
		end else begin
			state <= next_state;
			stop_prev <= stop_hit && state != ST_IDLE;
			POS_LOAD_STB <= 1'b0;
			OFFSET_MOVE <= 1'b0;
			MOTION_GO <= motion_req && !refuse;
			SEEK_ACTIVE <= (next_state == ST_SEEK) || (next_state == ST_SECOND);
			// Clamp from start until home is found, dropped before offset move
			clamp_on <= clamp_next;
			if (state == ST_IDLE && next_state == ST_SEEK) begin
				HOME_DONE <= 1'b0;
			end
			if ((state == ST_SEEK || state == ST_SECOND) && next_state != state && pos_mode) begin
				POS_LOAD <= home_position;
				POS_LOAD_STB <= 1'b1;
				HOME_DONE <= 1'b1;
				if (next_state == ST_OFFSET) begin
					OFFSET_MOVE <= 1'b1;
					OFFSET_DIST <= post_home_offset_move;
				end
			end
		end
	end

	// Current limits seen by the current loop
	always @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			LIMIT_POS <= `SHS_RST_DPEAK;
			LIMIT_NEG <= `SHS_RST_DPEAK;
		end else if (clamp_next) begin
			LIMIT_POS <= homing_current_clamp;
			LIMIT_NEG <= homing_current_clamp;
		end else begin
			LIMIT_POS <= positive_current_limit;
			LIMIT_NEG <= negative_current_limit;
		end
	end

	// ****************************************
	// Interrupts: set wins over clear
	// ****************************************
	always @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			irq_status <= 3'h0;
			IRQ <= 1'b0;
		end else begin
			irq_status <= (irq_status & ~((wr && ph_addr == `SHS_A_IRQCLR) ? HWDATA[2:0] : 3'h0))
				| {stop_edge && state != ST_IDLE && is_stop_mode(home_mode), refuse,
				(state != ST_IDLE && state != ST_OFFSET && next_state != state && pos_mode)};
			IRQ <= |(irq_status & irq_enable);
		end
	end
endmodule

// file: tb/shs_monitor.sv
// Checker for the homing sequencer, watching only its ports.
// Assumes binding to shs_top; one clock, async active-low reset.
module shs_monitor (
	input wire MCLK, // Clock
	input wire RST_B, // Reset, active low
	input wire POS_LOAD_STB, // Position load pulse
	input wire HOME_DONE, // Homing complete
	input wire SEEK_ACTIVE, // Search running
	input wire OFFSET_MOVE, // Offset move pulse
	input wire [15:0] LIMIT_POS, // Positive limit
	input wire [15:0] LIMIT_NEG, // Negative limit
	input wire HREADYOUT, // Bus ready
	input wire HRESP // Bus response
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [15:0] last;
	reg [15:0] prior;
	reg seek_d;
	// Limits held just before a search starts, kept for the restore check
	always @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			last <= 16'h7800;
			prior <= 16'h7800;
			seek_d <= 1'b0;
		end else begin
			last <= LIMIT_POS;
			seek_d <= SEEK_ACTIVE;
			if (SEEK_ACTIVE && !seek_d)
				prior <= last;
		end
	end
	// ****
	// Port relations
	// ****
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_B);
	a_limits_paired: assert property (LIMIT_POS == LIMIT_NEG) else $error("limits not symmetric");
	a_load_marks_done: assert property (POS_LOAD_STB |-> ##[0:1] HOME_DONE) else $error("load without done");
	a_load_single: assert property (POS_LOAD_STB |=> !POS_LOAD_STB) else $error("load pulse too long");
	a_load_in_search: assert property (POS_LOAD_STB |-> $past(SEEK_ACTIVE)) else $error("load outside search");
	a_done_after_search: assert property ($rose(HOME_DONE) |-> $past(SEEK_ACTIVE))
		else $error("done without search");
	a_offset_restored: assert property (OFFSET_MOVE |-> !SEEK_ACTIVE && LIMIT_POS == prior)
		else $error("limits not restored");
	a_offset_after_done: assert property (OFFSET_MOVE |-> HOME_DONE) else $error("offset before done");
	a_limits_idle: assert property (!SEEK_ACTIVE && !$past(SEEK_ACTIVE) && !$past(SEEK_ACTIVE, 2) |-> $stable(LIMIT_POS))
		else $error("limits moved while idle");
	a_bus_okay: assert property (HREADYOUT && !HRESP) else $error("bus not ready or not okay");
endmodule
bind shs_top shs_monitor shs_monitor_i (.MCLK(MCLK), .RST_B(RST_B), .POS_LOAD_STB(POS_LOAD_STB),
	.HOME_DONE(HOME_DONE), .SEEK_ACTIVE(SEEK_ACTIVE), .OFFSET_MOVE(OFFSET_MOVE), .LIMIT_POS(LIMIT_POS),
	.LIMIT_NEG(LIMIT_NEG), .HREADYOUT(HREADYOUT), .HRESP(HRESP));

// file: tb/shs_motor.sv
// Motor model: switches, marks and lag that answer the homing search.
// Assumes search and offset requests arrive synchronous to the clock.
module shs_motor (
	input wire mclk, // Clock
	input wire rst_b, // Reset, active low
	input wire seek, // Search running
	input wire offs, // Offset move start
	input wire [31:0] lag, // Lag once at the stop
	output wire [31:0] err, // Following error
	output wire lsw, // Limit switch
	output wire hsw, // Home switch
	output wire idx, // Index mark
	output wire zer, // Zero angle mark
	output reg done // Move finished
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [7:0] cnt;
	// Axis travel time since the search began; marks repeat so a late stage still sees one
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 8'h00;
			done <= 1'b0;
		end else begin
			cnt <= seek ? cnt + 8'h01 : 8'h00;
			done <= offs;
		end
	end
	// Switches close after four cycles, the stop builds lag after six
	assign lsw = cnt >= 8'h04;
	assign hsw = cnt >= 8'h04;
	assign idx = cnt[3:0] == 4'hC;
	assign zer = cnt[3:0] == 4'hC;
	assign err = cnt >= 8'h06 ? lag : 32'h00000000;
endmodule

// file: tb/tb.sv
// Bench for the homing sequencer: registers, every homing mode, motion gate.
// Assumes shs_top, the motor model and the checker are compiled first.
`include "shs_defines.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	reg MCLK = 1'b0;
	reg RST_B = 1'b0;
	reg [31:0] HADDR = 32'h00000000;
	reg [31:0] HWDATA = 32'h00000000;
	reg [1:0] HTRANS = 2'h0;
	reg HWRITE = 1'b0;
	reg HSEL = 1'b0;
	wire [31:0] HRDATA, FOLLOW_ERR, POS_LOAD, OFFSET_DIST;
	wire [15:0] LIMIT_POS, LIMIT_NEG;
	wire HREADYOUT, HRESP, LIMIT_SW, HOME_SW, INDEX_PULSE, ZERO_ANGLE, MOVE_DONE;
	wire POS_LOAD_STB, SEEK_ACTIVE, OFFSET_MOVE, MOTION_GO, HOME_DONE, IRQ;
	reg [31:0] rd, off_d;
	reg [15:0] off_l;
	integer err_total = 0, n_compared = 0, cyc = 0, n_go = 0, n_off = 0, i;
	// Clamp expected mid-search for each homing mode; zero where not checked
	logic [15:0] clamp [14] = '{0, 0, 0, 0, 0, 0, 0, 0, 16'h0040, 16'h0040, 0, 0, 0, 0};
	logic [7:0] ra [6] = '{`SHS_A_CTRL, `SHS_A_DPEAK, `SHS_A_HPEAK, `SHS_A_LIMP, `SHS_A_LIMN, 8'h3C};
	logic [31:0] rv [6] = '{32'h10, 32'h7800, 32'h0100, 32'h7800, 32'h7800, 32'h0};
	shs_top shs_top_i (.MCLK(MCLK), .RST_B(RST_B), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
		.HSIZE(3'h2), .HWDATA(HWDATA), .HSEL(HSEL), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
		.HRESP(HRESP), .FOLLOW_ERR(FOLLOW_ERR), .LIMIT_SW(LIMIT_SW), .HOME_SW(HOME_SW), .INDEX_PULSE(INDEX_PULSE),
		.ZERO_ANGLE(ZERO_ANGLE), .MOVE_DONE(MOVE_DONE), .POS_LOAD(POS_LOAD), .POS_LOAD_STB(POS_LOAD_STB),
		.LIMIT_POS(LIMIT_POS), .LIMIT_NEG(LIMIT_NEG), .SEEK_ACTIVE(SEEK_ACTIVE), .OFFSET_MOVE(OFFSET_MOVE),
		.OFFSET_DIST(OFFSET_DIST), .MOTION_GO(MOTION_GO), .HOME_DONE(HOME_DONE), .IRQ(IRQ));
	shs_motor shs_motor_i (.mclk(MCLK), .rst_b(RST_B), .seek(SEEK_ACTIVE), .offs(OFFSET_MOVE), .lag(32'hFFFFFE00),
		.err(FOLLOW_ERR), .lsw(LIMIT_SW), .hsw(HOME_SW), .idx(INDEX_PULSE), .zer(ZERO_ANGLE), .done(MOVE_DONE));
	initial forever #12.5 MCLK = ~MCLK;
	// Pulse counters and a ceiling on run length, since a hung search never ends
	always @(posedge MCLK) begin
		cyc <= cyc + 1;
		if (MOTION_GO === 1'b1)
			n_go <= n_go + 1;
		if (OFFSET_MOVE === 1'b1) begin
			n_off <= n_off + 1;
			off_d <= OFFSET_DIST;
			off_l <= LIMIT_POS;
		end
		if (cyc == 5000) begin
			err_total = err_total + 1;
			end_sim;
		end
	end
	// ****
	// Tasks
	// ****
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			err_total = err_total + 1;
			$display("wrong value %0s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One AHB single transfer; read data taken at the data-phase edge
	task bus(input w, input [7:0] a, input [31:0] d);
		@(posedge MCLK);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HWRITE <= w;
		HADDR <= {24'h000000, a};
		@(posedge MCLK);
		while (HREADYOUT !== 1'b1) @(posedge MCLK);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		@(posedge MCLK);
		while (HREADYOUT !== 1'b1) @(posedge MCLK);
		rd = HRDATA;
	endtask
	task end_sim;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ****
	// Main sequence
	// ****
	initial begin
		repeat (20) @(posedge MCLK);
		RST_B <= 1'b1;
		chk("lim", LIMIT_POS, 32'h7800);
		for (i = 0; i < 6; i++) begin
			bus(1'b0, ra[i], 32'h0);
			chk("reset", rd, rv[i]);
		end
		// Outside position mode, parameters and start do nothing
		bus(1'b1, `SHS_A_IRQEN, 32'h2);
		bus(1'b1, `SHS_A_HOMEP, 32'h1234);
		bus(1'b1, `SHS_A_CMD, 32'h1);
		repeat (10) @(posedge MCLK);
		chk("seek", SEEK_ACTIVE, 32'h0);
		bus(1'b0, `SHS_A_HOMEP, 32'h0);
		chk("homep", rd, 32'h0);
		// Position mode but wrong command source
		bus(1'b1, `SHS_A_CTRL, 32'h16);
		bus(1'b1, `SHS_A_CMD, 32'h1);
		repeat (10) @(posedge MCLK);
		chk("seek", SEEK_ACTIVE, 32'h0);
		// Motion before homing: refused, then allowed with the gate off
		bus(1'b1, `SHS_A_CTRL, 32'h12);
		bus(1'b1, `SHS_A_CMD, 32'h2);
		repeat (4) @(posedge MCLK);
		chk("go", n_go, 32'h0);
		chk("irq", IRQ, 32'h1);
		bus(1'b0, `SHS_A_IRQST, 32'h0);
		chk("irqst", rd, 32'h2);
		bus(1'b1, `SHS_A_IRQCLR, 32'h7);
		repeat (2) @(posedge MCLK);
		chk("irq", IRQ, 32'h0);
		bus(1'b1, `SHS_A_CTRL, 32'h02);
		bus(1'b1, `SHS_A_CMD, 32'h2);
		repeat (4) @(posedge MCLK);
		chk("go", n_go, 32'h1);
		bus(1'b1, `SHS_A_CTRL, 32'h12);
		bus(1'b1, `SHS_A_HOMEP, 32'h1234);
		bus(1'b1, `SHS_A_THRESH, 32'h100);
		bus(1'b1, `SHS_A_HPEAK, 32'h40);
		bus(1'b0, `SHS_A_HOMEP, 32'h0);
		chk("homep", rd, 32'h1234);
		// Every homing mode gives a position load; two-stage modes give one after each stage
		for (i = 0; i < 14; i++) begin
			bus(1'b1, `SHS_A_MODE, i);
			bus(1'b1, `SHS_A_CMD, 32'h1);
			repeat (60) if (SEEK_ACTIVE !== 1'b1) @(posedge MCLK);
			chk("seek", SEEK_ACTIVE, 32'h1);
			if (clamp[i] != 0) begin
				@(posedge MCLK);
				chk("clamp", LIMIT_POS, clamp[i]);
			end
			repeat (80) if (POS_LOAD_STB !== 1'b1) @(posedge MCLK);
			chk("stb", POS_LOAD_STB, 32'h1);
			chk("pos", POS_LOAD, 32'h1234);
			@(posedge MCLK);
			chk("done", HOME_DONE, 32'h1);
		end
		chk("offs", n_off, 32'h0);
		bus(1'b0, `SHS_A_IRQST, 32'h0);
		chk("irqst", rd & 32'h5, 32'h5);
		chk("irq", IRQ, 32'h0);
		bus(1'b1, `SHS_A_CMD, 32'h2);
		repeat (4) @(posedge MCLK);
		chk("go", n_go, 32'h2);
		// Stop homing with an offset: limits back before the extra move
		bus(1'b1, `SHS_A_DIST, 32'h55);
		bus(1'b1, `SHS_A_MODE, 32'h8);
		bus(1'b1, `SHS_A_CMD, 32'h1);
		repeat (60) @(posedge MCLK);
		chk("noff", n_off, 32'h1);
		chk("dist", off_d, 32'h55);
		chk("rest", off_l, 32'h7800);
		// Reset in mid-search: back to idle, limits and homing gate re-armed
		bus(1'b1, `SHS_A_CMD, 32'h1);
		repeat (3) @(posedge MCLK);
		chk("seek", SEEK_ACTIVE, 32'h1);
		RST_B <= 1'b0;
		repeat (3) @(posedge MCLK);
		RST_B <= 1'b1;
		@(posedge MCLK);
		chk("rseek", SEEK_ACTIVE, 32'h0);
		chk("rdone", HOME_DONE, 32'h0);
		chk("rlim", LIMIT_POS, 32'h7800);
		bus(1'b0, `SHS_A_CTRL, 32'h0);
		chk("rctrl", rd, 32'h10);
		end_sim;
	end
endmodule
